//--- rtl/pwmpt_pkg.sv
// Purpose: Shared constants for the PWM unit with its 8-bit period timer.
// Assumes: 32-bit classic Wishbone, one 8-bit register per aligned word.
// Notes: Data sits in byte lane 0; the upper lanes read as zero.
package pwmpt_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_PWM_CTL = 8'h00;
  localparam logic [7:0] ADDR_DUTY_HI = 8'h04;
  localparam logic [7:0] ADDR_CMP_HI = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_TMR_CTL = 8'h10;
  localparam logic [7:0] ADDR_TMR_CNT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h20;
  localparam logic [7:0] ADDR_CLK_CTL = 8'h24;
  localparam logic [23:0] RD_PAD = 24'h000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Implemented-bit masks.
  localparam logic [7:0] PWM_CTL_MASK = 8'h3F;
  localparam logic [7:0] TMR_CTL_MASK = 8'h7F;
  localparam logic [7:0] FLAG_MASK = 8'h06;
  localparam logic [7:0] CLK_CTL_MASK = 8'h01;
  // Reset values.
  localparam logic [7:0] RST_PWM_CTL = 8'h00;
  localparam logic [7:0] RST_DUTY_HI = 8'h00;
  localparam logic [7:0] RST_CMP_HI = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_TMR_CTL = 8'h00;
  localparam logic [7:0] RST_TMR_CNT = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  localparam logic [7:0] RST_CLK_CTL = 8'h00;
  // Field positions.
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 2;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam int DLOW_MSB = 5;
  localparam int DLOW_LSB = 4;
  localparam int TRUN_BIT = 2;
  localparam int TPRE_MSB = 1;
  localparam int TPRE_LSB = 0;
  localparam int TPOST_MSB = 6;
  localparam int TPOST_LSB = 3;
  localparam int FLAG_TOV_BIT = 1;
  localparam int FLAG_OSF_BIT = 2;
  localparam int DIR_PWM_BIT = 5;
  localparam int CLK_MON_BIT = 0;
  localparam int CLK_ALT_BIT = 1;
  // Prescale select codes and fine-counter limits (four clocks per timer step times prescale).
  localparam logic [1:0] PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PRE_SEL_4 = 2'h1;
  localparam logic [5:0] PRE_MAX_1 = 6'h03;
  localparam logic [5:0] PRE_MAX_4 = 6'h0F;
  localparam logic [5:0] PRE_MAX_16 = 6'h3F;
  localparam logic [5:0] PRE_ZERO = 6'h00;
  localparam logic [5:0] PRE_ONE = 6'h01;
  localparam logic [3:0] POST_ZERO = 4'h0;
  localparam logic [3:0] POST_ONE = 4'h1;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [9:0] DUTY_ZERO = 10'h000;
endpackage

//--- rtl/pwmpt_tmr_if.sv
// Purpose: Carries timer configuration and timer state between the unit's modules.
// Assumes: One clock; tick is a one-cycle enable.
// Notes: The control end is the top module.
`timescale 1ns/10ps
`default_nettype none
interface pwmpt_tmr_if;
  logic tick;
  logic run;
  logic [1:0] pre_sel;
  logic [3:0] post_sel;
  logic [7:0] period;
  logic load;
  logic [7:0] load_val;
  logic [7:0] count;
  logic [1:0] fine;
  logic start;
  logic post_evt;
  modport tmr (input tick, run, pre_sel, post_sel, period, load, load_val,
               output count, fine, start, post_evt);
  modport pwm (input tick, count, fine, start);
endinterface
`default_nettype wire

//--- rtl/pwmpt_timer.sv
// Purpose: 8-bit period timer with prescaler and postscaler.
// Assumes: tick already carries clock selection and sleep gating.
// Notes: start and post_evt are one-cycle pulses from flip-flops.
`timescale 1ns/10ps
`default_nettype none
module pwmpt_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timer link
  pwmpt_tmr_if.tmr t
);
  import pwmpt_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic [5:0] pre;
    logic [3:0] post;
    logic start;
    logic post_evt;
  } pwmpt_tmr_st_t;

  pwmpt_tmr_st_t st_reg;
  pwmpt_tmr_st_t st_next;
  logic [5:0] pre_max;

  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.post_evt = 1'b0;
    case (t.pre_sel)
      PRE_SEL_1: pre_max = PRE_MAX_1;
      PRE_SEL_4: pre_max = PRE_MAX_4;
      default: pre_max = PRE_MAX_16;
    endcase
    if (t.load) begin
      st_next.count = t.load_val;
      st_next.pre = PRE_ZERO;
    end else if (t.tick && t.run) begin
      if (st_reg.pre == pre_max) begin
        st_next.pre = PRE_ZERO;
        if (st_reg.count == t.period) begin
          st_next.count = RST_TMR_CNT;
          st_next.start = 1'b1;
          if (st_reg.post == t.post_sel) begin
            st_next.post = POST_ZERO;
            st_next.post_evt = 1'b1;
          end else begin
            st_next.post = st_reg.post + POST_ONE;
          end
        end else begin
          st_next.count = st_reg.count + CNT_ONE;
        end
      end else begin
        st_next.pre = st_reg.pre + PRE_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // The two fraction bits are the top bits of the fine counter, so the
  // ten-bit duty count keeps its full span at every prescale.
  assign t.fine = (t.pre_sel == PRE_SEL_1) ? st_reg.pre[1:0] :
                  (t.pre_sel == PRE_SEL_4) ? st_reg.pre[3:2] : st_reg.pre[5:4];
  assign t.count = st_reg.count;
  assign t.start = st_reg.start;
  assign t.post_evt = st_reg.post_evt;
endmodule
`default_nettype wire

//--- rtl/pwmpt_pwm_out.sv
// Purpose: Duty comparison and pulse output latch.
// Assumes: start marks the first cycle of each new period.
// Notes: The duty value is latched only at period start.
`timescale 1ns/10ps
`default_nettype none
module pwmpt_pwm_out (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic en_i,
  input wire logic [9:0] duty_i,
  // Timer link
  pwmpt_tmr_if.pwm t,
  // Results
  output logic out_o,
  output logic [9:0] duty_lat_o
);
  import pwmpt_pkg::*;

  typedef struct packed {
    logic out;
    logic [9:0] duty;
  } pwmpt_out_st_t;

  pwmpt_out_st_t st_reg;
  pwmpt_out_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!en_i) begin
      st_next.out = 1'b0;
    end else if (t.start) begin
      st_next.duty = duty_i;
      st_next.out = (duty_i != DUTY_ZERO);
    end else if (st_reg.out && ({t.count, t.fine} == st_reg.duty)) begin
      st_next.out = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_o = st_reg.out;
  assign duty_lat_o = st_reg.duty;
endmodule
`default_nettype wire

//--- rtl/pwmpt_top.sv
// Purpose: PWM unit with 8-bit period timer behind a Wishbone slave.
// Assumes: osc_tick_i and intosc_tick_i are one-cycle enables at the
//   primary and internal oscillator rates; clk_fail_i and sleep_i are synchronous.
// Notes: Writes take effect at the edge where ack is sampled high.
// Notes on behaviour
// - With monitor on, a failed primary clock switches the unit to internal ticks.
// - Any reset makes every port pin an input and restores all unit registers.
// - The period register bounds the timer; a match starts a new period.
// - Software selects PWM through the two-bit mode field of the control register.
// - Duty is duty high byte over control bits five and four.
// - Prescale select is timer control bits 1:0, postscale bits 6:3.
// - The timer counts only while the run bit, bit two, is set.
// - Unimplemented control bits ignore writes and read as zero.
// - Sleep freezes timer and output stage, the bus stays live; the pin keeps its level; resume on wake.
`timescale 1ns/10ps
`default_nettype none
module pwmpt_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clocking and power
  input wire logic osc_tick_i,
  input wire logic intosc_tick_i,
  input wire logic clk_fail_i,
  input wire logic sleep_i,
  // Pins and interrupt
  output logic pulse_output_pin_o,
  output logic pulse_output_pin_oe_o,
  output logic [7:0] port_c_direction_o,
  output logic irq_o
);
  import pwmpt_pkg::*;

  typedef struct packed {
    logic [7:0] pwm_control;
    logic [7:0] duty_high_byte;
    logic [7:0] compare_high_byte;
    logic [7:0] period_register;
    logic [7:0] timer_control;
    logic [7:0] irq_flags;
    logic [7:0] irq_enables;
    logic [7:0] port_c_direction;
    logic [7:0] clk_control;
    logic on_intosc;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic pin;
    logic pin_oe;
  } pwmpt_top_st_t;

  localparam pwmpt_top_st_t ST_RESET = '{
    pwm_control: RST_PWM_CTL,
    duty_high_byte: RST_DUTY_HI,
    compare_high_byte: RST_CMP_HI,
    period_register: RST_PERIOD,
    timer_control: RST_TMR_CTL,
    irq_flags: RST_FLAGS,
    irq_enables: RST_IRQ_EN,
    port_c_direction: RST_PORT_DIR,
    clk_control: RST_CLK_CTL,
    on_intosc: 1'b0,
    ack: 1'b0,
    dat: '0,
    irq: 1'b0,
    pin: 1'b0,
    pin_oe: 1'b0
  };

  pwmpt_top_st_t st_reg;
  pwmpt_top_st_t st_next;

  pwmpt_tmr_if tif();

  logic req;
  logic wr;
  logic [7:0] wbyte;
  logic pwm_mode;
  logic [9:0] duty_val;
  logic [9:0] duty_lat;
  logic pwm_out;
  logic [7:0] rd_byte;
  logic [7:0] events;

  // Bus access decode; only byte lane 0 carries data.
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && st_reg.ack && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // Mode and duty as seen by the output stage.
  assign pwm_mode = (st_reg.pwm_control[MODE_MSB:MODE_LSB] == MODE_PWM);
  assign duty_val = {st_reg.duty_high_byte,
                     st_reg.pwm_control[DLOW_MSB:DLOW_LSB]};

  // Unit tick: sleep freezes the timer and output stage, and a failed primary clock hands the
  // unit over to the internal oscillator, whose rate may differ.
  assign tif.tick = !sleep_i && (st_reg.on_intosc ? intosc_tick_i : osc_tick_i);
  assign tif.run = st_reg.timer_control[TRUN_BIT];
  assign tif.pre_sel = st_reg.timer_control[TPRE_MSB:TPRE_LSB];
  assign tif.post_sel = st_reg.timer_control[TPOST_MSB:TPOST_LSB];
  assign tif.period = st_reg.period_register;
  assign tif.load = wr && (wb_adr_i == ADDR_TMR_CNT);
  assign tif.load_val = wbyte;

  pwmpt_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(tif)
  );

  pwmpt_pwm_out u_out (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(pwm_mode),
    .duty_i(duty_val),
    .t(tif),
    .out_o(pwm_out),
    .duty_lat_o(duty_lat)
  );

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rd_byte = BYTE_ZERO;
    case (wb_adr_i)
      ADDR_PWM_CTL: rd_byte = st_reg.pwm_control & PWM_CTL_MASK;
      ADDR_DUTY_HI: rd_byte = st_reg.duty_high_byte;
      ADDR_CMP_HI: rd_byte = pwm_mode ? duty_lat[9:2] : st_reg.compare_high_byte;
      ADDR_PERIOD: rd_byte = st_reg.period_register;
      ADDR_TMR_CTL: rd_byte = st_reg.timer_control & TMR_CTL_MASK;
      ADDR_TMR_CNT: rd_byte = tif.count;
      ADDR_IRQ_FLAGS: rd_byte = st_reg.irq_flags;
      ADDR_IRQ_EN: rd_byte = st_reg.irq_enables;
      ADDR_PORT_DIR: rd_byte = st_reg.port_c_direction;
      ADDR_CLK_CTL: begin
        rd_byte = st_reg.clk_control;
        rd_byte[CLK_ALT_BIT] = st_reg.on_intosc;
      end
      default: rd_byte = BYTE_ZERO;
    endcase
  end

  // Hardware events that set sticky flags.
  always_comb begin
    events = BYTE_ZERO;
    events[FLAG_TOV_BIT] = tif.post_evt;
    events[FLAG_OSF_BIT] = !st_reg.on_intosc && st_reg.clk_control[CLK_MON_BIT]
                           && clk_fail_i;
  end

  always_comb begin
    st_next = st_reg;
    // Ack one cycle after the request and drop it the cycle after.
    st_next.ack = req && !st_reg.ack;
    if (req && !st_reg.ack) begin
      st_next.dat = {RD_PAD, rd_byte};
    end
    if (wr) begin
      case (wb_adr_i)
        ADDR_PWM_CTL: st_next.pwm_control = wbyte & PWM_CTL_MASK;
        ADDR_DUTY_HI: st_next.duty_high_byte = wbyte;
        ADDR_CMP_HI: begin
          if (!pwm_mode) begin
            st_next.compare_high_byte = wbyte;
          end
        end
        ADDR_PERIOD: st_next.period_register = wbyte;
        ADDR_TMR_CTL: st_next.timer_control = wbyte & TMR_CTL_MASK;
        ADDR_IRQ_FLAGS: st_next.irq_flags = st_reg.irq_flags & ~(wbyte & FLAG_MASK);
        ADDR_IRQ_EN: st_next.irq_enables = wbyte;
        ADDR_PORT_DIR: st_next.port_c_direction = wbyte;
        ADDR_CLK_CTL: st_next.clk_control = wbyte & CLK_CTL_MASK;
        default: st_next.clk_control = st_reg.clk_control;
      endcase
    end
    // A flag event in the cycle of its clear still sets the flag.
    st_next.irq_flags = st_next.irq_flags | (events & FLAG_MASK);
    // Once switched, the unit stays on the internal oscillator until reset.
    if (events[FLAG_OSF_BIT]) begin
      st_next.on_intosc = 1'b1;
    end
    st_next.irq = |(st_next.irq_flags & st_next.irq_enables & FLAG_MASK);
    // The pin level follows the output stage, which itself freezes in sleep.
    st_next.pin = pwm_out;
    st_next.pin_oe = !st_next.port_c_direction[DIR_PWM_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
  assign irq_o = st_reg.irq;
  assign pulse_output_pin_o = st_reg.pin;
  assign pulse_output_pin_oe_o = st_reg.pin_oe;
  assign port_c_direction_o = st_reg.port_c_direction;
endmodule
`default_nettype wire

//--- dv/pwmpt_checker.sv
// Purpose: Port-level assertions for the PWM unit with its period timer.
// Assumes: One clock; synchronous active-high reset.
// Notes: Bound to pwmpt_top below; sees only the top module's ports.
`timescale 1ns/10ps
`default_nettype none
module pwmpt_checker
  import pwmpt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Power and pins
  input wire logic sleep_i,
  input wire logic pulse_output_pin_o,
  input wire logic pulse_output_pin_oe_o,
  input wire logic [7:0] port_c_direction_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_dir_wr;
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_PORT_DIR;
  endsequence
  property p_unused(logic [7:0] a, logic [7:0] m);
    wb_ack_o && !wb_we_i && wb_adr_i == a |-> (wb_dat_o[7:0] & ~m) == BYTE_ZERO;
  endproperty
  AST_ACK_NEXT: assert property (s_req |=> s_ack_pulse)
    else $error("ack did not follow a request for exactly one cycle");
  AST_ACK_IDLE: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack without a request");
  AST_RST_STATE: assert property ($fell(rst_i) |-> port_c_direction_o == RST_PORT_DIR
    && !pulse_output_pin_oe_o && !irq_o && !wb_ack_o)
    else $error("outputs not at reset state after reset");
  AST_DIR_WR: assert property (s_dir_wr |=> port_c_direction_o == $past(wb_dat_i[7:0]))
    else $error("direction write did not land");
  AST_OE_DIR: assert property (pulse_output_pin_oe_o == !port_c_direction_o[DIR_PWM_BIT])
    else $error("output enable does not follow the direction bit");
  AST_SLEEP_HOLD: assert property (sleep_i ##1 sleep_i |=> $stable(pulse_output_pin_o))
    else $error("pin changed during sleep");
  AST_RD_PAD: assert property (wb_ack_o |-> wb_dat_o[31:8] == RD_PAD)
    else $error("upper read lanes not zero");
  AST_PWM_CTL_RSV: assert property (p_unused(ADDR_PWM_CTL, PWM_CTL_MASK))
    else $error("unimplemented control bits read nonzero");
  AST_TMR_CTL_RSV: assert property (p_unused(ADDR_TMR_CTL, TMR_CTL_MASK))
    else $error("unimplemented timer bits read nonzero");
endmodule
bind pwmpt_top pwmpt_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_i, .pulse_output_pin_o,
  .pulse_output_pin_oe_o, .port_c_direction_o, .irq_o);
`default_nettype wire

//--- dv/pwmpt_load.sv
// Purpose: External load on the pulse output pin that times the waveform.
// Assumes: The load pulls the line low when the pin is not driven.
// Notes: per_o and high_o refresh at each rising level.
`timescale 1ns/10ps
`default_nettype none
module pwmpt_load (
  // Clock
  input wire logic clk_i,
  // Pin
  input wire logic pin_i,
  input wire logic oe_i,
  // Measurements
  output int high_o,
  output int per_o
);
  logic lvl;
  logic lvl_d = 1'b0;
  int cnt = 0;
  int hi = 0;
  // A released line reads low, never the last driven value.
  assign lvl = oe_i ? pin_i : 1'b0;
  always @(posedge clk_i) begin
    lvl_d <= lvl;
    cnt <= cnt + 1;
    hi <= hi + int'(lvl);
    if (lvl && !lvl_d) begin
      per_o <= cnt;
      high_o <= hi;
      cnt <= 1;
      hi <= 1;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_pwm_with_period_timer.sv
// Purpose: Self-checking bench for the PWM unit with its period timer.
// Assumes: Classic Wishbone, one register per word, primary tick every cycle.
// Notes: A register model and a period formula predict every result.
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_with_period_timer;
  import pwmpt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic osc_en = 1'b1;
  logic osc_tick = 1'b0;
  logic int_tick = 1'b0;
  logic clk_fail = 1'b0;
  logic sleep = 1'b0;
  logic [31:0] rdat;
  logic ack;
  logic pin;
  logic pin_oe;
  logic irq;
  logic [7:0] dir;
  int per_o;
  int high_o;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0000C837;
  logic [7:0] mdl [0:9];
  logic [7:0] q;
  pwmpt_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .osc_tick_i(osc_tick), .intosc_tick_i(int_tick), .clk_fail_i(clk_fail), .sleep_i(sleep),
    .pulse_output_pin_o(pin), .pulse_output_pin_oe_o(pin_oe), .port_c_direction_o(dir),
    .irq_o(irq));
  pwmpt_load u_load (.clk_i(clk_i), .pin_i(pin), .oe_i(pin_oe), .high_o(high_o),
    .per_o(per_o));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    osc_tick <= osc_en;
    int_tick <= ~int_tick;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // The master never assumes a latency; only the watchdog ends a wait.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {RD_PAD, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    chk({8'h00, rdat[31:8]}, 32'h00000000);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    osc_en <= 1'b1;
    clk_fail <= 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl = '{RST_PWM_CTL, RST_DUTY_HI, RST_CMP_HI, RST_PERIOD, RST_TMR_CTL, RST_TMR_CNT,
      RST_FLAGS, RST_IRQ_EN, RST_PORT_DIR, RST_CLK_CTL};
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, 8'(i * 4), BYTE_ZERO);
      chk(q, mdl[i]);
    end
    wb(1'b0, 8'h40, BYTE_ZERO);
    chk(q, BYTE_ZERO);
    $display("test reset values finished");
  endtask
  task automatic pwm_run(input logic [1:0] ps, input logic [7:0] prd, input logic [9:0] dty,
    input int dv);
    int n;
    int pre;
    int ep;
    int eh;
    logic [7:0] p;
    n = 0;
    p = rnd();
    pre = (ps == PRE_SEL_1) ? 1 : (ps == PRE_SEL_4) ? 4 : 16;
    ep = (int'(prd) + 1) * 4 * pre * dv;
    eh = int'(dty) * pre * dv;
    wb(1'b1, ADDR_PORT_DIR, 8'hFF);
    // Stop and clear the timer so a count above the new period cannot delay the flag.
    wb(1'b1, ADDR_TMR_CTL, BYTE_ZERO);
    wb(1'b1, ADDR_TMR_CNT, BYTE_ZERO);
    wb(1'b1, ADDR_PERIOD, prd);
    wb(1'b1, ADDR_PWM_CTL, {2'h0, dty[1:0], MODE_PWM, 2'h0});
    wb(1'b1, ADDR_DUTY_HI, dty[9:2]);
    wb(1'b1, ADDR_IRQ_FLAGS, FLAG_MASK);
    wb(1'b1, ADDR_TMR_CTL, {3'h0, p[1:0], 1'b1, ps});
    do begin
      wb(1'b0, ADDR_IRQ_FLAGS, BYTE_ZERO);
      n++;
    end while (q[FLAG_TOV_BIT] !== 1'b1 && n < 6000);
    chk(q[FLAG_TOV_BIT], 1'b1);
    wb(1'b1, ADDR_PORT_DIR, 8'hDF);
    repeat (3 * ep + 20) @(posedge clk_i);
    chk(dir, 8'hDF);
    chk(per_o, ep);
    chk(high_o >= eh - dv && high_o <= eh + dv, 1'b1);
    wb(1'b0, ADDR_CMP_HI, BYTE_ZERO);
    chk(q, dty[9:2]);
    $display("test pwm prescale %0d period %0d finished", pre, ep);
  endtask
  initial begin
    logic [7:0] v;
    logic [7:0] prd;
    logic [7:0] wl [0:4];
    wl = '{ADDR_PWM_CTL, ADDR_DUTY_HI, ADDR_PERIOD, ADDR_TMR_CTL, ADDR_PORT_DIR};
    do_reset();
    for (int i = 0; i < 5; i++) begin
      v = rnd();
      wb(1'b1, wl[i], v);
      mdl[wl[i][5:2]] = v & ((wl[i] == ADDR_PWM_CTL) ? PWM_CTL_MASK :
        (wl[i] == ADDR_TMR_CTL) ? TMR_CTL_MASK : 8'hFF);
    end
    wb(1'b1, 8'h40, rnd());
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, wl[i], BYTE_ZERO);
      chk(q, mdl[wl[i][5:2]]);
    end
    $display("test register access finished");
    do_reset();
    for (int s = 0; s < 4; s++) begin
      prd = 8'h02 + (rnd() % 8);
      pwm_run(2'(s), prd, 10'(1 + rnd() % (4 * prd + 2)), 1);
    end
    wb(1'b1, ADDR_IRQ_EN, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b1, ADDR_IRQ_EN, BYTE_ZERO);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    @(posedge clk_i);
    sleep <= 1'b1;
    wb(1'b0, ADDR_TMR_CNT, BYTE_ZERO);
    v = q;
    repeat (40) @(posedge clk_i);
    wb(1'b0, ADDR_TMR_CNT, BYTE_ZERO);
    chk(q, v);
    sleep <= 1'b0;
    wb(1'b1, ADDR_TMR_CTL, BYTE_ZERO);
    wb(1'b1, ADDR_TMR_CNT, 8'h05);
    repeat (30) @(posedge clk_i);
    wb(1'b0, ADDR_TMR_CNT, BYTE_ZERO);
    chk(q, 8'h05);
    wb(1'b1, ADDR_IRQ_FLAGS, FLAG_MASK);
    wb(1'b0, ADDR_IRQ_FLAGS, BYTE_ZERO);
    chk(q, BYTE_ZERO);
    wb(1'b1, ADDR_IRQ_EN, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    $display("test interrupt sleep and hold finished");
    do_reset();
    wb(1'b1, ADDR_CLK_CTL, 8'h01);
    osc_en <= 1'b0;
    clk_fail <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, ADDR_IRQ_FLAGS, BYTE_ZERO);
    chk(q[FLAG_OSF_BIT], 1'b1);
    pwm_run(PRE_SEL_1, 8'h03, 10'h005, 2);
    conclude();
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
